// file: logic/dip_pkg.sv
/*
 Package of the digital input process image block: register map, field
 positions, reset values, timing constants and shared types.
 Assumes a single 50 MHz clock and a plain address/strobe register port.
*/
package dip_pkg;
	// Register byte offsets.
	localparam logic [7:0] DIP_OFS_CTRL = 8'h00;
	localparam logic [7:0] DIP_OFS_FAILSAFE = 8'h04;
	localparam logic [7:0] DIP_OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] DIP_OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] DIP_OFS_DIAG = 8'h10;
	localparam logic [7:0] DIP_OFS_IMAGE = 8'h14;
	// Field positions.
	localparam int DIP_CTRL_SWAP = 0;
	localparam int DIP_ST_UNDERVOLT = 5;
	localparam int DIP_ST_OVERLOAD = 4;
	localparam int DIP_IRQ_ALM_IN = 0;
	localparam int DIP_IRQ_ALM_OUT = 1;
	localparam int DIP_IRQ_READY = 2;
	// Reset values.
	localparam logic DIP_SWAP_RST = 1'b0;
	localparam logic [15:0] DIP_FAILSAFE_RST = 16'h0000;
	localparam logic [2:0] DIP_IRQ_RST = 3'h0;
	// Diagnostic sources: overtemperature, surge, sensor overload, four groups.
	localparam int DIP_NDIAG = 7;
	localparam int DIP_GROUP = 4;
	// Identification data; the manufacturer code is arbitrary.
	localparam logic [15:0] DIP_IM_MFR = 16'h1234;
	localparam logic [15:0] DIP_IM_VERSION = 16'h0101;
	localparam logic [15:0] DIP_IM_SUPPORTED = 16'h001e;
	localparam logic [15:0] DIP_IM_BLANK = 16'h2020;
	localparam logic [2:0] DIP_IM_LAST_REC = 3'h4;
	// Fast startup limit.
	localparam int DIP_STARTUP_MS = 500;
	localparam int DIP_CLK_KHZ = 50000;
	localparam int DIP_STARTUP_CYCLES = DIP_STARTUP_MS * DIP_CLK_KHZ - 1;

	typedef struct packed {
		logic [31:0] status;
		logic [7:0] byte1;
		logic [7:0] byte0;
	} dip_image_t;

	typedef struct packed {
		logic in_alarm;
		logic out_alarm;
		logic [2:0] source;
	} dip_alarm_t;

	typedef enum logic [1:0] {
		DIP_BOOT = 2'b01,
		DIP_RUN = 2'b10
	} dip_state_t;
endpackage

// file: logic/dip_top.sv
/*
 Digital input process image: cyclic status word and input bytes, indicator
 lights, diagnostic alarms, shared-device output grant, identification reads.
 Assumes all inputs synchronous to REF_CLK and one-cycle register strobes.
*/
// Summary of operation
// - Each input light follows its device input; labels are byte then bit.
// - Slot 1 always holds the four-byte status word.
// - Status word refreshed every cycle; bit 5 undervoltage, bit 4 overload.
// - Status bits 31..6 and 3..0 always read zero.
// - Unswapped: byte 0 carries inputs 1-8, byte 1 inputs 9-16.
// - Swap setting defaults off; on exchanges input bytes 0 and 1.
// - Swap never alters the failsafe substitute value.
// - A newly stored diagnostic entry sends an incoming alarm.
// - A removed diagnostic entry sends an outgoing alarm.
// - Station-fault light is on while any diagnostic entry is stored.
// - Entries come from overtemperature, sensor surge and sensor overload.
// - Channel diagnostics are reported per group of four channels.
// - With fast startup the block is ready in under 500 ms.
// - Two controllers may read; the first to connect gets output writing until it disconnects.
// - Identification records 0 to 4 are readable through slot 0.
`timescale 1ns/1ps
module dip_top import dip_pkg::*; #(
	parameter int STARTUP_CYCLES = DIP_STARTUP_CYCLES
) (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Field inputs and supply monitors.
	input wire logic [15:0] DEVICE_INPUT,
	input wire logic [15:0] CHANNEL_FAULT,
	input wire logic MODULE_UNDERVOLT,
	input wire logic MODULE_OVERLOAD,
	input wire logic DEVICE_OVERTEMP,
	input wire logic SENSOR_SURGE,
	input wire logic SENSOR_OVERLOAD,
	// Controller connections.
	input wire logic [1:0] CTRL_CONNECTED,
	input wire logic IM_RD_REQ,
	input wire logic [2:0] IM_RECORD,
	input wire logic [3:0] IM_WORD,
	// Register port.
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// Process image, alarms and grants.
	output dip_image_t PD_IMAGE,
	output logic [1:0] PD_VALID,
	output logic [1:0] OUT_GRANT,
	output dip_alarm_t ALARM,
	output logic [15:0] IM_RD_DATA,
	output logic IM_RD_VALID,
	output logic IM_RD_ERR,
	// Lights and interrupt.
	output logic [15:0] INPUT_LED,
	output logic STATION_FAULT_LED,
	output logic READY,
	output logic IRQ
);

	if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > DIP_STARTUP_CYCLES) begin : g_chk
		$error("STARTUP_CYCLES out of range");
	end

	function automatic logic [2:0] dip_lowest(input logic [DIP_NDIAG-1:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = DIP_NDIAG - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic dip_hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
		return s && (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register port.
	logic swap_reg;
	logic [15:0] failsafe_reg;
	logic [2:0] irq_stat_reg, irq_stat_next;
	logic [2:0] irq_mask_reg;
	logic [31:0] rdata_reg;
	logic [2:0] irq_ev;
	logic [DIP_NDIAG-1:0] stored_reg;

	wire wr_ctrl = dip_hit(REG_ADDR, DIP_OFS_CTRL, REG_WR);
	wire wr_fs = dip_hit(REG_ADDR, DIP_OFS_FAILSAFE, REG_WR);
	wire wr_stat = dip_hit(REG_ADDR, DIP_OFS_IRQ_STAT, REG_WR);
	wire wr_mask = dip_hit(REG_ADDR, DIP_OFS_IRQ_MASK, REG_WR);
	wire [2:0] stat_clr = wr_stat ? REG_WDATA[2:0] : 3'h0;
	// An event in the clearing cycle survives.
	assign irq_stat_next = (irq_stat_reg & ~stat_clr) | irq_ev;

	logic [31:0] rd_mux;
	always_comb begin
		case (REG_ADDR)
			DIP_OFS_CTRL: rd_mux = {31'h0, swap_reg};
			DIP_OFS_FAILSAFE: rd_mux = {16'h0, failsafe_reg};
			DIP_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
			DIP_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
			DIP_OFS_DIAG: rd_mux = {25'h0, stored_reg};
			DIP_OFS_IMAGE: rd_mux = {16'h0, PD_IMAGE.byte1, PD_IMAGE.byte0};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			swap_reg <= DIP_SWAP_RST;
			failsafe_reg <= DIP_FAILSAFE_RST;
			irq_stat_reg <= DIP_IRQ_RST;
			irq_mask_reg <= DIP_IRQ_RST;
			rdata_reg <= 32'h0;
			IRQ <= 1'b0;
		end else begin
			if (wr_ctrl) swap_reg <= REG_WDATA[DIP_CTRL_SWAP];
			// The substitute value has its own write path only.
			if (wr_fs) failsafe_reg <= REG_WDATA[15:0];
			if (wr_mask) irq_mask_reg <= REG_WDATA[2:0];
			irq_stat_reg <= irq_stat_next;
			rdata_reg <= REG_RD ? rd_mux : 32'h0;
			IRQ <= |(irq_stat_next & irq_mask_reg);
		end
	end
	assign REG_RDATA = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Fast startup.
	dip_state_t state_reg, state_next;
	logic [24:0] boot_cnt_reg;
	wire boot_done = boot_cnt_reg == 25'(STARTUP_CYCLES - 1);

	always_comb begin
		case (state_reg)
			DIP_BOOT: state_next = boot_done ? DIP_RUN : DIP_BOOT;
			DIP_RUN: state_next = DIP_RUN;
			default: state_next = DIP_BOOT;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= DIP_BOOT;
			boot_cnt_reg <= 25'h0;
			READY <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == DIP_BOOT) boot_cnt_reg <= boot_cnt_reg + 25'h1;
			READY <= state_next == DIP_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Process image and lights.
	wire [7:0] in_lo = DEVICE_INPUT[7:0];
	wire [7:0] in_hi = DEVICE_INPUT[15:8];
	dip_image_t image_next;
	always_comb begin
		image_next.status = 32'h0;
		image_next.status[DIP_ST_UNDERVOLT] = MODULE_UNDERVOLT;
		image_next.status[DIP_ST_OVERLOAD] = MODULE_OVERLOAD;
		// Status word is built apart from the swap path.
		image_next.byte0 = swap_reg ? in_hi : in_lo;
		image_next.byte1 = swap_reg ? in_lo : in_hi;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PD_IMAGE <= '0;
			INPUT_LED <= 16'h0;
		end else begin
			PD_IMAGE <= image_next;
			INPUT_LED <= DEVICE_INPUT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Diagnostics and alarms; one alarm per cycle, lowest source first.
	logic [DIP_GROUP-1:0] grp_fault;
	for (genvar g = 0; g < DIP_GROUP; g++) begin : g_grp
		assign grp_fault[g] = |CHANNEL_FAULT[4*g +: 4];
	end
	wire [DIP_NDIAG-1:0] diag_live = {grp_fault, SENSOR_OVERLOAD, SENSOR_SURGE, DEVICE_OVERTEMP};
	wire [DIP_NDIAG-1:0] diag_diff = diag_live ^ stored_reg;
	wire [2:0] diag_src = dip_lowest(diag_diff);
	wire diag_any = |diag_diff;
	wire diag_new = diag_any && diag_live[diag_src];
	wire [DIP_NDIAG-1:0] stored_next = stored_reg ^ (diag_any ? (7'h1 << diag_src) : 7'h0);
	assign irq_ev = {state_next == DIP_RUN && state_reg == DIP_BOOT,
		diag_any && !diag_new, diag_new};

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			stored_reg <= '0;
			ALARM <= '0;
			STATION_FAULT_LED <= 1'b0;
		end else begin
			stored_reg <= stored_next;
			ALARM.in_alarm <= diag_new;
			ALARM.out_alarm <= diag_any && !diag_new;
			ALARM.source <= diag_src;
			STATION_FAULT_LED <= |stored_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared device: the first controller to connect owns output writing.
	logic owner_valid_reg;
	logic owner_id_reg;
	wire owner_lost = owner_valid_reg && !CTRL_CONNECTED[owner_id_reg];
	wire take = (!owner_valid_reg || owner_lost) && |CTRL_CONNECTED;
	wire take_id = !CTRL_CONNECTED[0];

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			owner_valid_reg <= 1'b0;
			owner_id_reg <= 1'b0;
			OUT_GRANT <= 2'h0;
			PD_VALID <= 2'h0;
		end else begin
			if (take && !owner_valid_reg) begin
				owner_valid_reg <= 1'b1;
				owner_id_reg <= take_id;
			end else if (owner_lost) begin
				owner_valid_reg <= 1'b0;
			end
			OUT_GRANT <= (READY && owner_valid_reg && !owner_lost) ? (2'h1 << owner_id_reg) : 2'h0;
			PD_VALID <= READY ? CTRL_CONNECTED : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Identification reads through slot 0.
	logic [15:0] im_word;
	always_comb begin
		if (IM_RECORD != 3'h0) begin
			im_word = DIP_IM_BLANK;
		end else begin
			case (IM_WORD)
				4'h0: im_word = DIP_IM_MFR;
				4'h1: im_word = DIP_IM_VERSION;
				4'h2: im_word = DIP_IM_SUPPORTED;
				default: im_word = 16'h0;
			endcase
		end
	end
	wire im_ok = IM_RECORD <= DIP_IM_LAST_REC;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IM_RD_VALID <= 1'b0;
			IM_RD_ERR <= 1'b0;
			IM_RD_DATA <= 16'h0;
		end else begin
			IM_RD_VALID <= IM_RD_REQ && im_ok;
			IM_RD_ERR <= IM_RD_REQ && !im_ok;
			IM_RD_DATA <= (IM_RD_REQ && im_ok) ? im_word : 16'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_new_fault;
		!DEVICE_OVERTEMP ##1 DEVICE_OVERTEMP;
	endsequence
	sequence s_in_alarm;
		ALARM.in_alarm && ALARM.source == 3'h0;
	endsequence

	a_led_follow: assert property (INPUT_LED == $past(DEVICE_INPUT))
		else $error("input light differs from input");
	a_status_rsvd: assert property (PD_IMAGE.status[31:6] == 26'h0 && PD_IMAGE.status[3:0] == 4'h0)
		else $error("reserved status bit set");
	a_status_flags: assert property (PD_IMAGE.status[5:4] == $past({MODULE_UNDERVOLT, MODULE_OVERLOAD}))
		else $error("status flags wrong");
	a_bytes_plain: assert property (!$past(swap_reg) |-> {PD_IMAGE.byte1, PD_IMAGE.byte0} == $past(DEVICE_INPUT))
		else $error("unswapped byte order wrong");
	a_bytes_swap: assert property ($past(swap_reg) |-> PD_IMAGE.byte0 == $past(DEVICE_INPUT[15:8]))
		else $error("swapped byte order wrong");
	a_failsafe_keep: assert property (!wr_fs |=> $stable(failsafe_reg))
		else $error("substitute value changed");
	a_alarm_incoming: assert property (s_new_fault ##1 DEVICE_OVERTEMP |-> ##[0:7] s_in_alarm)
		else $error("no incoming alarm");
	a_alarm_outgoing: assert property (ALARM.out_alarm |-> !stored_reg[ALARM.source])
		else $error("outgoing alarm for stored entry");
	a_fault_light: assert property (STATION_FAULT_LED == |stored_reg)
		else $error("station fault light wrong");
	a_grant_single: assert property ($onehot0(OUT_GRANT) && (OUT_GRANT == 2'h0 || READY))
		else $error("output grant to two controllers");
	a_ready_time: assert property ($rose(READY) |-> boot_cnt_reg == 25'(STARTUP_CYCLES))
		else $error("ready at wrong time");
	a_im_read: assert property (IM_RD_REQ && IM_RECORD <= 3'h4 |=> IM_RD_VALID && !IM_RD_ERR)
		else $error("identification read refused");

	////////////////////////////////////////////////////////////////////////////
	// Further checks, grouped by the path that they guard.
	// A long-held condition must have reached the stored entries by then.
	sequence s_overtemp_held;
		DEVICE_OVERTEMP [*8];
	endsequence

	// Group 0 is next in line only while the three lower sources are settled.
	sequence s_group_pending;
		(|CHANNEL_FAULT[3:0]) && diag_live[2:0] == stored_reg[2:0];
	endsequence

	sequence s_bad_record;
		IM_RD_REQ && IM_RECORD > DIP_IM_LAST_REC;
	endsequence

	a_swap_hi: assert property (
		$past(swap_reg) |-> PD_IMAGE.byte1 == $past(DEVICE_INPUT[7:0]))
		else $error("swapped high byte wrong");

	a_swap_write: assert property (
		$past(wr_ctrl) |-> swap_reg == $past(REG_WDATA[DIP_CTRL_SWAP]))
		else $error("swap setting not taken");

	a_failsafe_write: assert property (
		$past(wr_fs) |-> failsafe_reg == $past(REG_WDATA[15:0]))
		else $error("substitute value not taken");

	a_status_noswap: assert property (
		$changed(swap_reg) |=> PD_IMAGE.status == {26'h0, $past(MODULE_UNDERVOLT), $past(MODULE_OVERLOAD), 4'h0})
		else $error("status word moved by swap");

	a_startup_quiet: assert property (
		state_reg == DIP_BOOT |-> !READY)
		else $error("ready during startup");

	a_ready_hold: assert property (
		READY |=> READY)
		else $error("ready dropped");

	a_in_entry: assert property (
		ALARM.in_alarm |-> stored_reg[ALARM.source])
		else $error("incoming alarm without entry");

	a_alarm_excl: assert property (
		!(ALARM.in_alarm && ALARM.out_alarm))
		else $error("both alarm directions at once");

	a_diag_store: assert property (
		s_overtemp_held |-> stored_reg[0])
		else $error("overtemperature entry missing");

	a_group_report: assert property (
		s_group_pending |=> stored_reg[3])
		else $error("group entry missing");

	a_grant_conn: assert property (
		OUT_GRANT != 2'h0 |-> ($past(CTRL_CONNECTED) & OUT_GRANT) == OUT_GRANT)
		else $error("grant to absent controller");

	a_pd_valid: assert property (
		PD_VALID == ($past(READY) ? $past(CTRL_CONNECTED) : 2'h0))
		else $error("input data valid wrong");

	a_im_refuse: assert property (
		s_bad_record |=> IM_RD_ERR && !IM_RD_VALID && IM_RD_DATA == 16'h0)
		else $error("bad record not refused");

endmodule

// file: tb/dip_ctrl_model.sv
/*
 Behavioural IO controller on the far side of the process image block.
 Assumes the bench asks for connections and runs identification reads.
*/
`timescale 1ns/1ps
module dip_ctrl_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Connection wishes from the bench.
	input wire logic [1:0] want,
	// Device side.
	output logic [1:0] conn,
	output logic im_req,
	output logic [2:0] im_rec,
	output logic [3:0] im_word,
	input wire logic [15:0] im_data,
	input wire logic im_valid,
	input wire logic im_err
);
	////////////////////////////////////////////////////////////////////////////
	// A link comes up one edge after it is asked for, so both may be held at once.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			conn <= 2'h0;
		else
			conn <= want;
	end

	initial begin
		im_req = 1'b0;
		im_rec = 3'h0;
		im_word = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Returns {valid, error, data}; the record lines are scrambled after use.
	task automatic read_im(input logic [2:0] rec, input logic [3:0] wd, output logic [17:0] r);
		@(posedge clk);
		im_req <= 1'b1;
		im_rec <= rec;
		im_word <= wd;
		@(posedge clk);
		im_req <= 1'b0;
		im_rec <= ~rec;
		im_word <= ~wd;
		#1;
		r = {im_valid, im_err, im_data};
	endtask
endmodule

// file: tb/dip_top_tb.sv
/*
 Self-checking bench of the process image block with a controller model.
 Assumes the startup count is shortened to keep the run brief.
*/
`timescale 1ns/1ps
module dip_top_tb;
	import dip_pkg::*;
	localparam int STARTUP_LIM = 20;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [15:0] DEVICE_INPUT = 16'h0000;
	logic [15:0] CHANNEL_FAULT = 16'h0000;
	logic MODULE_UNDERVOLT = 1'b0;
	logic MODULE_OVERLOAD = 1'b0;
	logic [2:0] cond = 3'h0;
	logic [1:0] want = 2'h0;
	logic [1:0] CTRL_CONNECTED;
	logic IM_RD_REQ;
	logic [2:0] IM_RECORD;
	logic [3:0] IM_WORD;
	logic [7:0] REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	dip_image_t PD_IMAGE;
	logic [1:0] PD_VALID;
	logic [1:0] OUT_GRANT;
	dip_alarm_t ALARM;
	logic [15:0] IM_RD_DATA;
	logic IM_RD_VALID;
	logic IM_RD_ERR;
	logic [15:0] INPUT_LED;
	logic STATION_FAULT_LED;
	logic READY;
	logic IRQ;
	integer seed = 71;
	int n_fail = 0;
	int samples_checked = 0;
	int i;
	int s;
	int sw;
	logic [31:0] rnd;
	logic [31:0] rd_val;
	logic [17:0] im_val;
	logic [15:0] din;

	always #10 REF_CLK = ~REF_CLK;

	dip_top #(.STARTUP_CYCLES(STARTUP_LIM)) u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
		.DEVICE_INPUT(DEVICE_INPUT), .CHANNEL_FAULT(CHANNEL_FAULT), .MODULE_UNDERVOLT(MODULE_UNDERVOLT),
		.MODULE_OVERLOAD(MODULE_OVERLOAD), .DEVICE_OVERTEMP(cond[0]), .SENSOR_SURGE(cond[1]),
		.SENSOR_OVERLOAD(cond[2]), .CTRL_CONNECTED(CTRL_CONNECTED), .IM_RD_REQ(IM_RD_REQ),
		.IM_RECORD(IM_RECORD), .IM_WORD(IM_WORD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PD_IMAGE(PD_IMAGE), .PD_VALID(PD_VALID),
		.OUT_GRANT(OUT_GRANT), .ALARM(ALARM), .IM_RD_DATA(IM_RD_DATA), .IM_RD_VALID(IM_RD_VALID),
		.IM_RD_ERR(IM_RD_ERR), .INPUT_LED(INPUT_LED), .STATION_FAULT_LED(STATION_FAULT_LED),
		.READY(READY), .IRQ(IRQ));

	dip_ctrl_model u_ctrl (.clk(REF_CLK), .rst_n(RST_N), .want(want), .conn(CTRL_CONNECTED),
		.im_req(IM_RD_REQ), .im_rec(IM_RECORD), .im_word(IM_WORD), .im_data(IM_RD_DATA),
		.im_valid(IM_RD_VALID), .im_err(IM_RD_ERR));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge REF_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1;
		d = REG_RDATA;
	endtask

	task automatic wait_alarm(input logic dir_in, input logic [2:0] src);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 10 && !hit; k++) begin
			tick(1);
			hit = (dir_in ? ALARM.in_alarm : ALARM.out_alarm) === 1'b1;
		end
		chk("alarm pulse", hit, 1'b1);
		chk("alarm source", ALARM.source, src);
	endtask

	function automatic logic [47:0] exp_img(input logic [15:0] di, input logic uv, input logic ol, input int swp);
		logic [31:0] st;
		st = 32'h0;
		st[5] = uv;
		st[4] = ol;
		return (swp != 0) ? {st, di[7:0], di[15:8]} : {st, di[15:8], di[7:0]};
	endfunction

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		n_fail++;
		close_out;
	end

	initial begin
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1'b1;
		rd(DIP_OFS_CTRL, rd_val);
		chk("swap reset", rd_val, 32'h0);
		rd(DIP_OFS_FAILSAFE, rd_val);
		chk("failsafe reset", rd_val, 32'h0);
		rd(8'hfc, rd_val);
		chk("unmapped read", rd_val, 32'h0);
		chk("ready early", READY, 1'b0);
		tick(STARTUP_LIM);
		chk("ready late", READY, 1'b1);
		rd(DIP_OFS_IRQ_STAT, rd_val);
		chk("ready event", rd_val, 32'h4);
		wr(DIP_OFS_IRQ_STAT, 32'h7);
		wr(DIP_OFS_IRQ_MASK, 32'h3);
		for (sw = 0; sw < 2; sw++) begin
			wr(DIP_OFS_CTRL, sw);
			wr(DIP_OFS_FAILSAFE, 32'h5a3c);
			rd(DIP_OFS_FAILSAFE, rd_val);
			chk("failsafe", rd_val, 32'h5a3c);
			for (i = 0; i < 12; i++) begin
				rnd = $random(seed);
				din = (i == 0) ? 16'h00ff : (i == 1) ? 16'h8001 : rnd[31:16];
				@(posedge REF_CLK);
				DEVICE_INPUT <= din;
				MODULE_UNDERVOLT <= rnd[0];
				MODULE_OVERLOAD <= rnd[1];
				tick(3);
				chk("image", PD_IMAGE, exp_img(din, rnd[0], rnd[1], sw));
				chk("input lights", INPUT_LED, din);
			end
			rd(DIP_OFS_IMAGE, rd_val);
			chk("image reg", rd_val, exp_img(din, 1'b0, 1'b0, sw));
		end
		for (s = 0; s < 7; s++) begin
			if (s == 6)
				wr(DIP_OFS_IRQ_MASK, 32'h0);
			rnd = $random(seed);
			@(posedge REF_CLK);
			if (s < 3)
				cond[s] <= 1'b1;
			else
				CHANNEL_FAULT <= 16'h1 << ((s - 3) * 4 + rnd[1:0]);
			wait_alarm(1'b1, s);
			chk("fault light on", STATION_FAULT_LED, 1'b1);
			chk("irq", IRQ, s != 6);
			rd(DIP_OFS_DIAG, rd_val);
			chk("stored entries", rd_val, 32'h1 << s);
			@(posedge REF_CLK);
			cond <= 3'h0;
			CHANNEL_FAULT <= 16'h0;
			wait_alarm(1'b0, s);
			tick(1);
			chk("fault light off", STATION_FAULT_LED, 1'b0);
			rd(DIP_OFS_IRQ_STAT, rd_val);
			chk("alarm events", rd_val, 32'h3);
			wr(DIP_OFS_IRQ_STAT, 32'h3);
			tick(1);
			chk("irq cleared", IRQ, 1'b0);
		end
		@(posedge REF_CLK);
		want <= 2'b10;
		tick(5);
		chk("grant first", OUT_GRANT, 2'b10);
		@(posedge REF_CLK);
		want <= 2'b11;
		tick(5);
		chk("grant kept", OUT_GRANT, 2'b10);
		chk("both read", PD_VALID, 2'b11);
		@(posedge REF_CLK);
		want <= 2'b01;
		tick(5);
		chk("grant moved", OUT_GRANT, 2'b01);
		u_ctrl.read_im(3'h0, 4'h0, im_val);
		chk("im maker", im_val, {2'b10, DIP_IM_MFR});
		u_ctrl.read_im(3'h0, 4'h1, im_val);
		chk("im version", im_val, {2'b10, 16'h0101});
		u_ctrl.read_im(3'h0, 4'h2, im_val);
		chk("im supported", im_val, {2'b10, 16'h001e});
		for (i = 1; i < 5; i++) begin
			rnd = $random(seed);
			u_ctrl.read_im(i, rnd[3:0], im_val);
			chk("im record", im_val, {2'b10, 16'h2020});
		end
		u_ctrl.read_im(3'h5, 4'h0, im_val);
		chk("im refused", im_val, {2'b01, 16'h0});
		close_out;
	end
endmodule
